// File: core/acc_pkg.sv
// Package with the constants of the converter calibration control block.
package acc_pkg;
    localparam logic [7:0] ACC_CAL_CTRL_ADDR = 8'hF5;
    localparam logic [7:0] ACC_CAL_CTRL_RESET = 8'h00;
    localparam int ACC_BUSY_BIT = 7;
    localparam int ACC_GAIN_DIS_BIT = 6;
    localparam int ACC_AVG_HI_BIT = 5;
    localparam int ACC_AVG_LO_BIT = 4;
    localparam int ACC_OFFS_DIS_BIT = 3;
    localparam int ACC_MODE_BIT = 2;
    localparam int ACC_TYPE_BIT = 1;
    localparam int ACC_START_BIT = 0;
    localparam int ACC_CNT_W = 6;
    localparam logic [5:0] ACC_AVG_CODE0 = 6'h0F;
    localparam logic [5:0] ACC_AVG_CODE1 = 6'h1F;
    localparam logic [5:0] ACC_AVG_CODE2 = 6'h2F;
    localparam logic [5:0] ACC_AVG_CODE3 = 6'h3F;
    localparam int ACC_EXT_CH = 6;
    localparam int ACC_INT_SRC = 5;
    localparam logic [3:0] ACC_CH_TEMP = 4'h8;
    localparam logic [3:0] ACC_CH_VREF = 4'hC;
    localparam int ACC_INT_AGND = 3;
    localparam int ACC_INT_VREF = 4;
    localparam int ACC_CAL_BITS = 12;
    typedef enum logic [1:0] {
        ACC_IDLE = 2'b00,
        ACC_CONV = 2'b01,
        ACC_CAL = 2'b11,
        ACC_FINISH = 2'b10
    } acc_state_e;
endpackage

// File: core/acc_count_if.sv
// Interface between the sequencer and the reading counter.
`timescale 1ns/100ps
`default_nettype none
interface acc_count_if;
    logic clear;
    logic pulse;
    logic [5:0] target;
    logic last;
    modport ctrl (output clear, output pulse, output target, input last);
    modport cnt (input clear, input pulse, input target, output last);
endinterface
`default_nettype wire

// File: core/acc_reading_counter.sv
// Counter of converter readings within one calibration bit decision.
`timescale 1ns/100ps
`default_nettype none
module acc_reading_counter
    import acc_pkg::*;
#(
    parameter int CNT_W = ACC_CNT_W
) (
    input wire logic clock, // System clock.
    input wire logic rst, // Synchronous reset, active high.
    acc_count_if.cnt cif // Clear, reading pulse, target and last flag.
);
    logic [CNT_W-1:0] count_r;

    // Last is high with the pulse that completes the target number of readings.
    assign cif.last = cif.pulse && (count_r == CNT_W'(cif.target - 6'h01));

    always_ff @(posedge clock) begin
        if (rst || cif.clear) begin
            count_r <= '0;
        end else if (cif.last) begin
            count_r <= '0;
        end else if (cif.pulse) begin
            count_r <= count_r + CNT_W'(1);
        end
    end
endmodule
`default_nettype wire

// File: core/acc_adc_calibration_control.sv
// Calibration and status control register with channel routing for the converter.
`timescale 1ns/100ps
`default_nettype none
module acc_adc_calibration_control
    import acc_pkg::*;
#(
    parameter int CAL_BITS = ACC_CAL_BITS
) (
    input wire logic clock, // System clock, 20 MHz.
    input wire logic rst, // Synchronous reset, active high.
    input wire logic [7:0] sfrAddr, // SFR address.
    input wire logic [7:0] sfrWrData, // SFR write data.
    input wire logic sfrWrEn, // SFR write strobe.
    input wire logic sfrRdEn, // SFR read strobe.
    output logic [7:0] sfrRdData, // SFR read data, valid the cycle after the strobe.
    output logic sfrRdValid, // Read data valid pulse.
    input wire logic [3:0] channelSel, // Channel selection field.
    input wire logic convStart, // Conversion request pulse.
    input wire logic convDone, // End of conversion pulse from the converter.
    input wire logic readingDone, // End of one calibration reading.
    output logic [ACC_EXT_CH-1:0] extChannelEn, // One-hot external input switch.
    output logic [ACC_INT_SRC-1:0] intSourceEn, // One-hot internal source switch.
    output logic readingReq, // Request pulse for one calibration reading.
    output logic calFullScale, // Calibration in progress is full scale.
    output logic calModeSel, // Calibration mode bit to the converter.
    output logic calActive, // Calibration in progress.
    output logic gainCorrEn, // Apply gain coefficient to results.
    output logic offsetCorrEn // Apply offset coefficient to results.
);
    acc_state_e state_r;
    acc_state_e state_nxt;
    logic gainDis_r;
    logic [1:0] avgSel_r;
    logic offsDis_r;
    logic mode_r;
    logic type_r;
    logic start_r;
    logic busy_r;
    logic [3:0] bitIdx_r;
    logic regWrite;
    logic startWrite;
    logic calLastBit;
    logic calComplete;
    acc_count_if cif ();

    assign regWrite = sfrWrEn && (sfrAddr == ACC_CAL_CTRL_ADDR);
    assign startWrite = regWrite && sfrWrData[ACC_START_BIT];
    assign calLastBit = (bitIdx_r == 4'(CAL_BITS - 1));
    assign calComplete = (state_r == ACC_CAL) && cif.last && calLastBit;

    // Reading counter target per bit decision.
    always_comb begin
        case (avgSel_r)
            2'b00: cif.target = ACC_AVG_CODE0;
            2'b01: cif.target = ACC_AVG_CODE1;
            2'b10: cif.target = ACC_AVG_CODE2;
            default: cif.target = ACC_AVG_CODE3;
        endcase
    end
    assign cif.pulse = (state_r == ACC_CAL) && readingDone;
    assign cif.clear = (state_r != ACC_CAL);

    acc_reading_counter #(
        .CNT_W(ACC_CNT_W)
    ) u_count (
        .clock(clock),
        .rst(rst),
        .cif(cif)
    );

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ACC_IDLE: begin
                if (start_r) begin
                    state_nxt = ACC_CAL;
                end else if (convStart) begin
                    state_nxt = ACC_CONV;
                end
            end
            ACC_CONV: begin
                if (convDone) begin
                    state_nxt = ACC_IDLE;
                end
            end
            ACC_CAL: begin
                if (calComplete) begin
                    state_nxt = ACC_FINISH;
                end
            end
            ACC_FINISH: state_nxt = ACC_IDLE;
            default: state_nxt = ACC_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_r <= ACC_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Busy follows the cycle state; software writes never reach it.
    always_ff @(posedge clock) begin
        if (rst) begin
            busy_r <= 1'b0;
        end else begin
            busy_r <= (state_nxt == ACC_CONV) || (state_nxt == ACC_CAL);
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            gainDis_r <= ACC_CAL_CTRL_RESET[ACC_GAIN_DIS_BIT];
            avgSel_r <= ACC_CAL_CTRL_RESET[ACC_AVG_HI_BIT:ACC_AVG_LO_BIT];
            offsDis_r <= ACC_CAL_CTRL_RESET[ACC_OFFS_DIS_BIT];
            mode_r <= ACC_CAL_CTRL_RESET[ACC_MODE_BIT];
            type_r <= ACC_CAL_CTRL_RESET[ACC_TYPE_BIT];
        end else if (regWrite) begin
            gainDis_r <= sfrWrData[ACC_GAIN_DIS_BIT];
            avgSel_r <= sfrWrData[ACC_AVG_HI_BIT:ACC_AVG_LO_BIT];
            offsDis_r <= sfrWrData[ACC_OFFS_DIS_BIT];
            mode_r <= sfrWrData[ACC_MODE_BIT];
            type_r <= sfrWrData[ACC_TYPE_BIT];
        end
    end

    // A write of 1 in the completion cycle wins and starts a new cycle.
    always_ff @(posedge clock) begin
        if (rst) begin
            start_r <= ACC_CAL_CTRL_RESET[ACC_START_BIT];
        end else if (startWrite) begin
            start_r <= 1'b1;
        end else if (calComplete) begin
            start_r <= 1'b0;
        end
    end

    // The type is frozen for the whole calibration cycle.
    always_ff @(posedge clock) begin
        if (rst) begin
            calFullScale <= 1'b0;
            calActive <= 1'b0;
        end else begin
            if ((state_r == ACC_IDLE) && start_r) begin
                calFullScale <= type_r;
            end
            calActive <= (state_nxt == ACC_CAL);
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            bitIdx_r <= 4'h0;
            readingReq <= 1'b0;
        end else begin
            if (state_r != ACC_CAL) begin
                bitIdx_r <= 4'h0;
            end else if (cif.last && !calLastBit) begin
                bitIdx_r <= bitIdx_r + 4'h1;
            end
            readingReq <= ((state_r == ACC_IDLE) && start_r) ||
                          ((state_r == ACC_CAL) && readingDone && !calComplete);
        end
    end

    // Input routing for conversions and calibrations.
    always_ff @(posedge clock) begin
        if (rst) begin
            extChannelEn <= '0;
            intSourceEn <= '0;
        end else if ((state_r == ACC_IDLE) && start_r) begin
            extChannelEn <= '0;
            intSourceEn <= '0;
            if (type_r) begin
                intSourceEn[ACC_INT_VREF] <= 1'b1;
            end else begin
                intSourceEn[ACC_INT_AGND] <= 1'b1;
            end
        end else if ((state_r == ACC_IDLE) && convStart) begin
            extChannelEn <= '0;
            intSourceEn <= '0;
            if (channelSel < 4'(ACC_EXT_CH)) begin
                extChannelEn[channelSel[2:0]] <= 1'b1;
            end else if ((channelSel >= ACC_CH_TEMP) && (channelSel <= ACC_CH_VREF)) begin
                intSourceEn[3'(channelSel - ACC_CH_TEMP)] <= 1'b1;
            end
            // Codes 0110, 0111 and above 1100 leave every switch open.
        end else if (state_nxt == ACC_IDLE) begin
            extChannelEn <= '0;
            intSourceEn <= '0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            gainCorrEn <= 1'b1;
            offsetCorrEn <= 1'b1;
            calModeSel <= 1'b0;
        end else begin
            gainCorrEn <= !gainDis_r;
            offsetCorrEn <= !offsDis_r;
            calModeSel <= mode_r;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            sfrRdData <= 8'h00;
            sfrRdValid <= 1'b0;
        end else begin
            sfrRdValid <= sfrRdEn;
            if (sfrRdEn && (sfrAddr == ACC_CAL_CTRL_ADDR)) begin
                sfrRdData <= {busy_r, gainDis_r, avgSel_r, offsDis_r, mode_r, type_r,
                              start_r};
            end else begin
                sfrRdData <= 8'h00;
            end
        end
    end
endmodule
`default_nettype wire

// File: tb/acc_cal_asserts.sv
// Checker of the calibration control block port behaviour.
`timescale 1ns/100ps
`default_nettype none
module acc_cal_asserts
    import acc_pkg::*;
#(
    parameter int CAL_BITS = ACC_CAL_BITS
) (
    input wire logic clock, // Clock.
    input wire logic rst, // Reset.
    input wire logic [7:0] sfrAddr, // Address.
    input wire logic [7:0] sfrWrData, // Write data.
    input wire logic sfrWrEn, // Write strobe.
    input wire logic sfrRdEn, // Read strobe.
    input wire logic [7:0] sfrRdData, // Read data.
    input wire logic sfrRdValid, // Read valid.
    input wire logic [3:0] channelSel, // Channel code.
    input wire logic convStart, // Conversion request.
    input wire logic convDone, // Conversion end.
    input wire logic readingDone, // Reading end.
    input wire logic [ACC_EXT_CH-1:0] extChannelEn, // External switches.
    input wire logic [ACC_INT_SRC-1:0] intSourceEn, // Internal switches.
    input wire logic readingReq, // Reading request.
    input wire logic calFullScale, // Full scale.
    input wire logic calModeSel, // Mode out.
    input wire logic calActive, // Calibrating.
    input wire logic gainCorrEn, // Gain correction.
    input wire logic offsetCorrEn // Offset correction.
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    sequence wrReg;
        sfrWrEn && sfrAddr == ACC_CAL_CTRL_ADDR;
    endsequence
    sequence calRd;
        sfrRdEn && sfrAddr == ACC_CAL_CTRL_ADDR && calActive;
    endsequence
    rd_valid_a: assert property (sfrRdEn |=> sfrRdValid)
        else $error("read valid missing");
    rd_unmapped_a: assert property (sfrRdEn && sfrAddr != ACC_CAL_CTRL_ADDR |=>
        sfrRdData == 8'h00)
        else $error("unmapped read not zero");
    gain_follow_a: assert property (wrReg |=> ##1 gainCorrEn == !$past(sfrWrData[6], 2))
        else $error("gain enable wrong");
    offs_follow_a: assert property (wrReg |=> ##1 offsetCorrEn == !$past(sfrWrData[3], 2))
        else $error("offset enable wrong");
    cal_busy_a: assert property (calRd |=> sfrRdData[7] && sfrRdData[0])
        else $error("busy or start low in calibration");
    ext_route_a: assert property ($rose(|extChannelEn) |->
        $past(convStart) && extChannelEn == (6'h01 << $past(channelSel)))
        else $error("external switch wrong");
    src_onehot_a: assert property ($onehot0(intSourceEn) &&
        !(|extChannelEn && |intSourceEn))
        else $error("switches not one hot");
    cal_route_a: assert property (calActive |->
        intSourceEn == (calFullScale ? 5'h10 : 5'h08))
        else $error("calibration source wrong");
    req_in_cal_a: assert property (readingReq |-> calActive)
        else $error("reading request outside calibration");
endmodule
bind acc_adc_calibration_control acc_cal_asserts #(.CAL_BITS(CAL_BITS)) chk_u (.clock, .rst,
    .sfrAddr, .sfrWrData, .sfrWrEn, .sfrRdEn, .sfrRdData, .sfrRdValid, .channelSel, .convStart,
    .convDone, .readingDone, .extChannelEn, .intSourceEn, .readingReq, .calFullScale,
    .calModeSel, .calActive, .gainCorrEn, .offsetCorrEn);
`default_nettype wire

// File: tb/test_adc_calibration_control.sv
// Self-checking bench of the converter calibration control block.
`timescale 1ns/100ps
`default_nettype none
module test_adc_calibration_control
    import acc_pkg::*;
;
    logic clock, rst, sfrWrEn, sfrRdEn, convStart, convDone, readingDone;
    logic [7:0] sfrAddr, sfrWrData, sfrRdData, mdl, seen;
    logic [3:0] channelSel;
    logic sfrRdValid, readingReq, calFullScale, calModeSel, calActive, gainCorrEn, offsetCorrEn;
    logic [ACC_EXT_CH-1:0] extChannelEn;
    logic [ACC_INT_SRC-1:0] intSourceEn;
    logic [31:0] seed;
    int nErrors, checkCount, nReq, nRd, i;
    acc_adc_calibration_control #(.CAL_BITS(2)) dut_u (.clock, .rst, .sfrAddr, .sfrWrData,
        .sfrWrEn, .sfrRdEn, .sfrRdData, .sfrRdValid, .channelSel, .convStart, .convDone,
        .readingDone, .extChannelEn, .intSourceEn, .readingReq, .calFullScale, .calModeSel,
        .calActive, .gainCorrEn, .offsetCorrEn);
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checkCount++;
        if (got !== exp) begin
            nErrors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic close_out;
        if (nErrors == 0 && checkCount > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic wr(input logic [7:0] d);
        @(negedge clock);
        sfrAddr = ACC_CAL_CTRL_ADDR;
        sfrWrData = d;
        sfrWrEn = 1'b1;
        @(negedge clock);
        sfrWrEn = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(negedge clock);
        sfrAddr = a;
        sfrRdEn = 1'b1;
        @(negedge clock);
        sfrRdEn = 1'b0;
        chk(what, exp, sfrRdData);
        chk("rd_valid", 8'h01, {7'h00, sfrRdValid});
    endtask
    initial begin
        {sfrWrEn, sfrRdEn, convStart, convDone, readingDone, channelSel} = '0;
        {sfrAddr, sfrWrData, nErrors, checkCount} = '0;
        seed = 32'h3C4B;
        rst = 1'b1;
        repeat (12) @(negedge clock);
        rst = 1'b0;
        chk("corr_rst", 8'h03, {6'h00, gainCorrEn, offsetCorrEn});
        rd(ACC_CAL_CTRL_ADDR, ACC_CAL_CTRL_RESET, "reg_rst");
        rd(8'hF4, 8'h00, "unmapped");
        repeat (4) begin
            seed = xs(seed);
            wr(seed[7:0] & 8'hFE);
            mdl = seed[7:0] & 8'h7E;
            rd(ACC_CAL_CTRL_ADDR, mdl, "cfg");
            seen = {5'h00, gainCorrEn, offsetCorrEn, calModeSel};
            chk("corr", {5'h00, !mdl[6], !mdl[3], mdl[2]}, seen);
        end
        for (int c = 0; c < 16; c++) begin
            @(negedge clock);
            channelSel = c[3:0];
            convStart = 1'b1;
            @(negedge clock);
            convStart = 1'b0;
            channelSel = ~channelSel;
            rd(ACC_CAL_CTRL_ADDR, {1'b1, mdl[6:0]}, "conv_busy");
            chk("ext", (c < 6) ? 8'h01 << c : 8'h00, {2'b00, extChannelEn});
            chk("int", c > 7 && c < 13 ? 8'h01 << (c - 8) : 8'h00, {3'h0, intSourceEn});
            @(negedge clock);
            convDone = 1'b1;
            @(negedge clock);
            convDone = 1'b0;
            rd(ACC_CAL_CTRL_ADDR, mdl, "conv_end");
            chk("sw_open", 8'h00, {2'b00, extChannelEn} | {3'b000, intSourceEn});
        end
        for (int a = 0; a < 4; a++) begin
            mdl = {1'b0, mdl[6], a[1:0], mdl[3], 1'b1, a[0], 1'b0};
            wr(mdl | 8'h01);
            nReq = 0;
            nRd = 2 * (15 + 16 * a);
            for (i = 0; i < 3000 && !(i > 3 && !calActive); i++) begin
                @(negedge clock);
                readingDone = readingReq;
                if (readingReq) nReq++;
                sfrRdEn = (i == 5);
                convStart = (i == 8);
                if (i == 6) chk("cal_reg", {1'b1, mdl[6:1], 1'b1}, sfrRdData);
                if (i == 6) chk("cal_type", {7'h00, a[0]}, {7'h00, calFullScale});
                if (i == 10) chk("cal_conv", 8'h00, {2'b00, extChannelEn});
                if (i > 3 && calActive) begin
                    chk("cal_src", a[0] ? 8'h10 : 8'h08, {3'h0, intSourceEn});
                end
            end
            if (i >= 3000) begin
                nErrors++;
                break;
            end
            readingDone = 1'b0;
            chk("readings", nRd[7:0], nReq[7:0]);
            rd(ACC_CAL_CTRL_ADDR, mdl, "cal_end");
        end
        close_out();
    end
endmodule
`default_nettype wire
